// ### include/pct_map.svh
// Purpose: Constants of the pulse counter and tachometer block
// Assumes: 200 MHz clock, one measuring gate of one second
// Notes:   The gate length in cycles can be overridden by the top parameter GATE_CYC
// What this block does
// [R1] Input source: logic, low-side or high-side contact
// [R2] Speed mode divides pulse rate by divisor
// [R3] Decimal point trades resolution for display range
// [R4] Speed menu: input, divisor, point, output
// [R5] Up counter starts at zero, counts up
// [R6] Down counter starts at full scale, counts down
// [R7] Held reset input keeps count at start
// [R8] Count survives power loss, resumes after restart
// [R9] Count only on the selected input edge
// [R10] Prescaler passes one pulse per N edges
// [R11] Full-scale count sets top of counting range
// [R12] Display scaled linearly to full-scale display value
// [R13] Limit off: count runs to absolute maximum
// [R14] Limit error mode flags over or under range
// [R15] Limit clamp mode shows upper limit or zero
// [R16] Down counter lower limit fixed at zero
// [R17] Counter menu order from source to output
// [R18] Input synchronised, each edge counted once
// [R19] Rate above 10 kHz always flags error
`ifndef PCT_MAP_SVH
`define PCT_MAP_SVH

// ==========================================================
// Timing
`define PCT_CLK_HZ      200000000
`define PCT_GATE_MS     1000
`define PCT_GATE_CYC    (`PCT_CLK_HZ / 1000 * `PCT_GATE_MS)
`define PCT_MAX_HZ      10000
`define PCT_MAX_EDGES   (`PCT_MAX_HZ * `PCT_GATE_MS / 1000)
`define PCT_SEC_PER_MIN 60

// ==========================================================
// Ranges and reset values
`define PCT_DISP_MAX    16'h270F
`define PCT_ABS_MAX     17'sh0270F
`define PCT_POINT_MAX   16'h0002
`define PCT_RST_DIV     16'h0001
`define PCT_RST_FULL    16'h270F
`define PCT_RST_DHI     16'h270F

`endif

// ### include/pct_pkg.sv
// Purpose: Types shared by the pulse counter and tachometer files
// Assumes: Constants come from pct_map.svh
// Notes:   Enumerations follow the menu wording of the block
package pct_pkg;

    // ==========================================================
    // Modes and options
    typedef enum logic [1:0] {MODE_SPEED, MODE_UP, MODE_DOWN} pct_mode_type;
    typedef enum logic [1:0] {SRC_LOGIC, SRC_LOW_SIDE, SRC_HIGH_SIDE} pct_src_type;
    typedef enum logic [1:0] {LIM_OFF, LIM_ERROR, LIM_CLAMP} pct_lim_type;
    typedef enum logic [3:0] {MN_INPUT_TYPE, MN_INPUT_SOURCE, MN_EDGE, MN_DIVISOR, MN_FULL_SCALE,
                              MN_POINT, MN_DISP_HIGH, MN_LIMIT, MN_OUTPUT_CONFIG} pct_menu_type;
    typedef logic signed [16:0] pct_cnt_type;

    // ==========================================================
    // Carriers
    typedef struct packed {
        pct_mode_type mode;
        pct_src_type  src;
        logic         falling_edge_option;
        logic [15:0]  divisor;
        logic [15:0]  full_scale_count;
        logic [1:0]   decimal_point_position;
        logic [15:0]  full_scale_display_value;
        pct_lim_type  range_limit_mode;
    } pct_cfg_type;

    typedef struct packed {
        logic [15:0] value;
        logic [1:0]  point;
        logic        minus;
        logic        err;
    } pct_disp_type;

endpackage

// ### design/pct_edge_sync.sv
// Purpose: Synchronise the pulse pin and pick out the chosen edge
// Assumes: Pin is free of bounce
// Notes:   Edge pulse lags the pin by three clocks
`include "pct_map.svh"
module pct_edge_sync
    import pct_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic sys_rst_i,
    input  wire logic pin_i,
    input  wire logic invert_i,
    input  wire logic fall_i,
    output logic      edge_o
);
    logic sync1_r, sync2_r, prev_r, edge_r;
    logic lvl_w, prev_nxt, edge_nxt;

    // ==========================================================
    // Edge select; first stage feeds only the second
    always_comb
    begin
        lvl_w    = sync2_r ^ invert_i;                           // [R1]
        prev_nxt = lvl_w;
        edge_nxt = (lvl_w != prev_r) && (lvl_w == !fall_i);     // [R9] [R18]
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            prev_r  <= 1'b0;
            edge_r  <= 1'b0;
        end
        else
        begin
            sync1_r <= pin_i;
            sync2_r <= sync1_r;
            prev_r  <= prev_nxt;
            edge_r  <= edge_nxt;
        end
    end

    assign edge_o = edge_r;

    AST_EDGE_ONCE: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R18]
        edge_o |=> !edge_o) else $error("edge pulse longer than one cycle");
    AST_EDGE_DIR: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R9]
        edge_o |-> prev_r == !$past(fall_i)) else $error("edge of wrong direction");

endmodule // pct_edge_sync

// ### design/pct_div.sv
// Purpose: Serial restoring divider, one quotient bit per clock
// Assumes: Divisor is never zero and below two to the W-1
// Notes:   Quotient holds until the next start
`include "pct_map.svh"
module pct_div
    import pct_pkg::*;
#(
    parameter int unsigned W = 32
)
(
    input  wire logic         clk_i,
    input  wire logic         sys_rst_i,
    input  wire logic         start_i,
    input  wire logic [W-1:0] num_i,
    input  wire logic [W-1:0] den_i,
    output logic              busy_o,
    output logic              done_o,
    output logic [W-1:0]      quo_o
);
    typedef enum logic {DV_IDLE, DV_RUN} pct_dv_type;
    pct_dv_type   st_r, st_nxt;
    logic [W-1:0] rem_r, rem_nxt, q_r, q_nxt, den_r, den_nxt, sh_w;
    logic [5:0]   n_r, n_nxt;
    logic         done_r, done_nxt;

    // ==========================================================
    // Shift and subtract
    always_comb
    begin
        st_nxt   = st_r;
        rem_nxt  = rem_r;
        q_nxt    = q_r;
        den_nxt  = den_r;
        n_nxt    = n_r;
        done_nxt = 1'b0;
        sh_w     = {rem_r[W-2:0], q_r[W-1]};
        unique case (st_r)
            DV_IDLE:
                if (start_i)
                begin
                    st_nxt  = DV_RUN;
                    rem_nxt = '0;
                    q_nxt   = num_i;
                    den_nxt = den_i;
                    n_nxt   = 6'(W - 1);
                end
            DV_RUN:
            begin
                rem_nxt = (sh_w >= den_r) ? sh_w - den_r : sh_w;
                q_nxt   = {q_r[W-2:0], sh_w >= den_r};
                n_nxt   = n_r - 6'h01;
                if (n_r == 6'h00)
                begin
                    st_nxt   = DV_IDLE;
                    done_nxt = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            st_r   <= DV_IDLE;
            rem_r  <= '0;
            q_r    <= '0;
            den_r  <= '0;
            n_r    <= 6'h00;
            done_r <= 1'b0;
        end
        else
        begin
            st_r   <= st_nxt;
            rem_r  <= rem_nxt;
            q_r    <= q_nxt;
            den_r  <= den_nxt;
            n_r    <= n_nxt;
            done_r <= done_nxt;
        end
    end

    assign busy_o = (st_r == DV_RUN);
    assign done_o = done_r;
    assign quo_o  = q_r;

endmodule // pct_div

// ### design/pct_top.sv
// Purpose: Tachometer and up/down pulse counter with button menu
// Assumes: Buttons give one-cycle pulses; outside storage keeps the count
// Notes:   Speed figures assume the default one-second gate
`include "pct_map.svh"
module pct_top
    import pct_pkg::*;
#(
    parameter int unsigned GATE_CYC = `PCT_GATE_CYC
)
(
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        pulse_i,
    input  wire logic        hold_rst_n_i,
    input  wire logic        btn_ok_i,
    input  wire logic        btn_up_i,
    input  wire logic        btn_dn_i,
    input  wire pct_cnt_type nv_count_i,
    output pct_cfg_type      cfg_o,
    output pct_menu_type     menu_o,
    output pct_disp_type     disp_o,
    output pct_cnt_type      nv_count_o,
    output logic             nv_wr_o
);
    localparam pct_cfg_type CFG_RST = '{mode: MODE_SPEED, src: SRC_LOGIC, falling_edge_option: 1'b0,
        divisor: `PCT_RST_DIV, full_scale_count: `PCT_RST_FULL, decimal_point_position: 2'h0,
        full_scale_display_value: `PCT_RST_DHI, range_limit_mode: LIM_OFF};

    pct_cfg_type  cfg_r, cfg_nxt;
    pct_menu_type menu_r, menu_nxt;
    pct_disp_type disp_r, disp_nxt;
    pct_cnt_type  cnt_r, cnt_nxt, start_w, full_w;
    logic [15:0]  pre_r, pre_nxt, edges_r, edges_nxt, held_r, held_nxt;
    logic [15:0]  cur_w, lo_w, hi_w, edit_w, mag_w;
    logic [31:0]  gate_r, gate_nxt, num_w, den_w, scale_w, quo_w;
    logic         restore_r, wr_r, wr_nxt, hz_over_r, hz_over_nxt, pend_r, pend_nxt;
    logic         speed_w, edge_w, tick_w, gate_end_w, above_w, below_w;
    logic         div_start_w, div_busy_w, div_done_w;

    function automatic logic [15:0] bump(input logic [15:0] v, input logic [15:0] lo,
                                         input logic [15:0] hi, input logic up);
        bump = v;
        if (up && v < hi)
            bump = v + 16'h0001;
        else if (!up && v > lo)
            bump = v - 16'h0001;
    endfunction

    assign speed_w = (cfg_r.mode == MODE_SPEED);

    // ==========================================================
    // Menu: OK advances, up and down edit the shown item
    always_comb
    begin
        cur_w = 16'h0000;
        lo_w  = 16'h0000;
        hi_w  = `PCT_POINT_MAX;
        unique case (menu_r)
            MN_INPUT_TYPE:    cur_w = {14'h0000, cfg_r.mode};
            MN_INPUT_SOURCE:  cur_w = {14'h0000, cfg_r.src};                      // [R1]
            MN_EDGE:          cur_w = {15'h0000, cfg_r.falling_edge_option};
            MN_DIVISOR:       {cur_w, lo_w, hi_w} = {cfg_r.divisor, 16'h0001, 16'hFFFF};
            MN_FULL_SCALE:    {cur_w, lo_w, hi_w} = {cfg_r.full_scale_count, 16'h0001, `PCT_DISP_MAX}; // [R11]
            MN_POINT:         cur_w = {14'h0000, cfg_r.decimal_point_position};
            MN_DISP_HIGH:     {cur_w, hi_w} = {cfg_r.full_scale_display_value, `PCT_DISP_MAX};
            MN_LIMIT:         cur_w = {14'h0000, cfg_r.range_limit_mode};
            MN_OUTPUT_CONFIG: hi_w = 16'h0000;
        endcase
        if (menu_r == MN_EDGE)
            hi_w = 16'h0001;
        edit_w   = bump(cur_w, lo_w, hi_w, btn_up_i);
        menu_nxt = menu_r;
        cfg_nxt  = cfg_r;
        if (btn_ok_i)
        begin
            unique case (menu_r)                                                  // [R4] [R17]
                MN_INPUT_TYPE:    menu_nxt = MN_INPUT_SOURCE;
                MN_INPUT_SOURCE:  menu_nxt = speed_w ? MN_DIVISOR : MN_EDGE;
                MN_EDGE:          menu_nxt = MN_DIVISOR;
                MN_DIVISOR:       menu_nxt = speed_w ? MN_POINT : MN_FULL_SCALE;
                MN_FULL_SCALE:    menu_nxt = MN_POINT;
                MN_POINT:         menu_nxt = speed_w ? MN_OUTPUT_CONFIG : MN_DISP_HIGH;
                MN_DISP_HIGH:     menu_nxt = MN_LIMIT;
                MN_LIMIT:         menu_nxt = MN_OUTPUT_CONFIG;
                MN_OUTPUT_CONFIG: menu_nxt = MN_INPUT_TYPE;
            endcase
        end
        else if (btn_up_i ^ btn_dn_i)
        begin
            unique case (menu_r)
                MN_INPUT_TYPE:    cfg_nxt.mode = pct_mode_type'(edit_w[1:0]);
                MN_INPUT_SOURCE:  cfg_nxt.src = pct_src_type'(edit_w[1:0]);
                MN_EDGE:          cfg_nxt.falling_edge_option = edit_w[0];
                MN_DIVISOR:       cfg_nxt.divisor = edit_w;
                MN_FULL_SCALE:    cfg_nxt.full_scale_count = edit_w;
                MN_POINT:         cfg_nxt.decimal_point_position = edit_w[1:0];
                MN_DISP_HIGH:     cfg_nxt.full_scale_display_value = edit_w;
                MN_LIMIT:         cfg_nxt.range_limit_mode = pct_lim_type'(edit_w[1:0]);
                MN_OUTPUT_CONFIG: cfg_nxt = cfg_r;
            endcase
        end
    end

    // ==========================================================
    // Pulse pin: low-side contact idles high, so it is inverted
    pct_edge_sync u_edge (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .pin_i     (pulse_i),
        .invert_i  (cfg_r.src == SRC_LOW_SIDE),                                  // [R1]
        .fall_i    (cfg_r.falling_edge_option),                                  // [R9]
        .edge_o    (edge_w)
    );

    // ==========================================================
    // Prescaler and counter; a divisor lowered below the phase wraps on the next edge
    assign full_w  = {1'b0, cfg_r.full_scale_count};
    assign start_w = (cfg_r.mode == MODE_DOWN) ? full_w : 17'sh00000;            // [R5] [R6]
    assign tick_w  = edge_w && !speed_w && (pre_r >= cfg_r.divisor - 16'h0001); // [R10]

    always_comb
    begin
        pre_nxt = pre_r;
        cnt_nxt = cnt_r;
        if (restore_r)
            cnt_nxt = nv_count_i;                                                 // [R8]
        else if (!hold_rst_n_i)
        begin
            cnt_nxt = start_w;                                                    // [R7]
            pre_nxt = 16'h0000;
        end
        else if (edge_w && !speed_w)
        begin
            pre_nxt = tick_w ? 16'h0000 : pre_r + 16'h0001;                       // [R10]
            if (tick_w && cfg_r.mode == MODE_UP && cnt_r < `PCT_ABS_MAX)
                cnt_nxt = cnt_r + 17'sh00001;                                     // [R5] [R13]
            else if (tick_w && cfg_r.mode == MODE_DOWN && cnt_r > -`PCT_ABS_MAX)
                cnt_nxt = cnt_r - 17'sh00001;                                     // [R6] [R13]
        end
        wr_nxt = (cnt_nxt != cnt_r);                                              // [R8]
    end

    // ==========================================================
    // Rate gate; runs in every mode so the 10 kHz check always applies
    assign gate_end_w = (gate_r == 32'(GATE_CYC - 1));

    always_comb
    begin
        gate_nxt    = gate_end_w ? 32'h00000000 : gate_r + 32'h00000001;
        edges_nxt   = (edge_w && edges_r != 16'hFFFF) ? edges_r + 16'h0001 : edges_r;
        held_nxt    = held_r;
        hz_over_nxt = hz_over_r;
        pend_nxt    = pend_r && !div_start_w;
        if (gate_end_w)
        begin
            edges_nxt   = {15'h0000, edge_w};
            held_nxt    = edges_r;
            hz_over_nxt = (edges_r > 16'(`PCT_MAX_EDGES));                       // [R19]
            pend_nxt    = 1'b1;
        end
    end

    // ==========================================================
    // Scaling: rpm = edges * 60 / divisor, count = |n| * high / full
    assign mag_w       = (cnt_r < 17'sh00000) ? 16'(-cnt_r) : cnt_r[15:0];
    assign above_w     = (cnt_r > full_w);
    assign below_w     = (cnt_r < 17'sh00000);                                   // [R16]
    assign div_start_w = !div_busy_w && !div_done_w && (!speed_w || pend_r);

    always_comb
    begin
        unique case (cfg_r.decimal_point_position)                                // [R3]
            2'h1:    scale_w = 32'h0000000A;
            2'h2:    scale_w = 32'h00000064;
            default: scale_w = 32'h00000001;
        endcase
        if (speed_w)
        begin
            num_w = 32'(held_r) * 32'(`PCT_SEC_PER_MIN) * scale_w;               // [R2]
            den_w = {16'h0000, cfg_r.divisor};
        end
        else
        begin
            num_w = 32'(mag_w) * 32'(cfg_r.full_scale_display_value);             // [R12]
            den_w = {16'h0000, cfg_r.full_scale_count};
        end
    end

    pct_div #(.W(32)) u_div (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .start_i   (div_start_w),
        .num_i     (num_w),
        .den_i     (den_w),
        .busy_o    (div_busy_w),
        .done_o    (div_done_w),
        .quo_o     (quo_w)
    );

    // ==========================================================
    // Display update when a quotient lands
    always_comb
    begin
        disp_nxt = disp_r;
        if (div_done_w)
        begin
            disp_nxt.value = quo_w[15:0];
            disp_nxt.point = cfg_r.decimal_point_position;
            disp_nxt.minus = !speed_w && below_w;
            disp_nxt.err   = hz_over_r || (quo_w > 32'(`PCT_DISP_MAX));          // [R3] [R19]
            if (!speed_w)
            begin
                unique case (cfg_r.range_limit_mode)
                    LIM_ERROR:
                        if (above_w || below_w)
                            disp_nxt.err = 1'b1;                                  // [R14]
                    LIM_CLAMP:
                        if (above_w || below_w)
                        begin
                            disp_nxt.value = above_w ? cfg_r.full_scale_display_value : 16'h0000; // [R15]
                            disp_nxt.minus = 1'b0;
                            disp_nxt.err   = hz_over_r;
                        end
                    default:
                        disp_nxt.err = disp_nxt.err;                              // [R13]
                endcase
            end
        end
    end

    // ==========================================================
    // State registers; restore is taken on the first clock after reset
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            cfg_r     <= CFG_RST;
            menu_r    <= MN_INPUT_TYPE;
            disp_r    <= '0;
            cnt_r     <= 17'sh00000;
            pre_r     <= 16'h0000;
            restore_r <= 1'b1;
            wr_r      <= 1'b0;
            gate_r    <= 32'h00000000;
            edges_r   <= 16'h0000;
            held_r    <= 16'h0000;
            hz_over_r <= 1'b0;
            pend_r    <= 1'b0;
        end
        else
        begin
            cfg_r     <= cfg_nxt;
            menu_r    <= menu_nxt;
            disp_r    <= disp_nxt;
            cnt_r     <= cnt_nxt;
            pre_r     <= pre_nxt;
            restore_r <= 1'b0;
            wr_r      <= wr_nxt;
            gate_r    <= gate_nxt;
            edges_r   <= edges_nxt;
            held_r    <= held_nxt;
            hz_over_r <= hz_over_nxt;
            pend_r    <= pend_nxt;
        end
    end

    assign cfg_o      = cfg_r;
    assign menu_o     = menu_r;
    assign disp_o     = disp_r;
    assign nv_count_o = cnt_r;
    assign nv_wr_o    = wr_r;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    AST_HOLD_START: assert property (!restore_r && !hold_rst_n_i |=> cnt_r == $past(start_w)) // [R7]
        else $error("held count left its start value");
    AST_UP_STEP: assert property (!restore_r && hold_rst_n_i && tick_w && cfg_r.mode == MODE_UP // [R5]
        && cnt_r < `PCT_ABS_MAX |=> cnt_r == $past(cnt_r) + 17'sh00001) else $error("up count missed");
    AST_DOWN_STEP: assert property (!restore_r && hold_rst_n_i && tick_w && cfg_r.mode == MODE_DOWN // [R6]
        && cnt_r > -`PCT_ABS_MAX |=> cnt_r == $past(cnt_r) - 17'sh00001) else $error("down count missed");
    AST_PRESCALE: assert property (!restore_r && hold_rst_n_i && edge_w && !speed_w && !tick_w // [R10]
        |=> pre_r == $past(pre_r) + 16'h0001 && $stable(cnt_r)) else $error("prescaler leaked a pulse");
    AST_RESTORE: assert property (restore_r |=> cnt_r == $past(nv_count_i)) // [R8]
        else $error("stored count not restored");
    AST_MENU_SPEED: assert property (btn_ok_i && speed_w && menu_r == MN_DIVISOR // [R4]
        |=> menu_r == MN_POINT) else $error("speed menu order wrong");
    AST_MENU_COUNT: assert property (btn_ok_i && !speed_w && menu_r == MN_DIVISOR // [R17]
        |=> menu_r == MN_FULL_SCALE) else $error("counter menu order wrong");
    AST_LIMIT_ERR: assert property (div_done_w && !speed_w && cfg_r.range_limit_mode == LIM_ERROR // [R14]
        && (above_w || below_w) |=> disp_o.err) else $error("range error not shown");
    AST_LIMIT_CLAMP: assert property (div_done_w && !speed_w && cfg_r.range_limit_mode == LIM_CLAMP // [R15]
        && above_w |=> disp_o.value == $past(cfg_r.full_scale_display_value)) else $error("clamp value wrong");
    AST_RATE_ERR: assert property (div_done_w && hz_over_r |=> disp_o.err) // [R19]
        else $error("over-rate error not shown");

endmodule // pct_top

// ### bench/pct_pulse_src.sv
// Purpose: Pulse transmitter model on the pulse pin
// Assumes: Bounce-free source, one level flip per request
// Notes:   Caller spaces requests by five clocks
module pct_pulse_src
(
    input  wire logic clk_i,
    input  wire logic tgl_i,
    output logic      pulse_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // ==========================================================
    // Pin level: low at start, flips on request
    initial pulse_o = 1'b0;
    always @(posedge clk_i)
    begin
        if (tgl_i)
            pulse_o <= ~pulse_o; // Level stands five clocks
    end
endmodule // pct_pulse_src

// ### bench/tb_pct_top.sv
// Purpose: Self-checking bench of the pulse counter and tachometer
// Assumes: Short gate, one button at a time
// Notes:   Divisor 3 and full scale 4 are set through the menu
module tb_pct_top
    import pct_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic         clk_i = 1'b0;
    logic         sys_rst_i = 1'b1;
    logic         hold_rst_n = 1'b1;
    logic         ok = 1'b0;
    logic         up = 1'b0;
    logic         dn = 1'b0;
    logic         tgl = 1'b0;
    logic         pin;
    logic         nv_wr;
    pct_cfg_type  cfg;
    pct_menu_type menu;
    pct_disp_type disp;
    pct_cnt_type  cnt;
    int           n_errors = 0;
    int           samples_checked = 0;
    pct_menu_type sp[5] = '{MN_INPUT_SOURCE, MN_DIVISOR, MN_POINT, MN_OUTPUT_CONFIG, MN_INPUT_TYPE};
    pct_menu_type cn[9] = '{MN_INPUT_SOURCE, MN_EDGE, MN_DIVISOR, MN_FULL_SCALE, MN_POINT,
                            MN_DISP_HIGH, MN_LIMIT, MN_OUTPUT_CONFIG, MN_INPUT_TYPE};
    // ==========================================================
    // Design and transmitter; restore value fixed at 7
    pct_top #(.GATE_CYC(2000)) u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .pulse_i(pin),
        .hold_rst_n_i(hold_rst_n), .btn_ok_i(ok), .btn_up_i(up), .btn_dn_i(dn),
        .nv_count_i(17'sh00007), .cfg_o(cfg), .menu_o(menu), .disp_o(disp),
        .nv_count_o(cnt), .nv_wr_o(nv_wr));
    pct_pulse_src u_src (.clk_i(clk_i), .tgl_i(tgl), .pulse_o(pin));
    initial
        forever #2.5 clk_i = ~clk_i;
    // ==========================================================
    // Access tasks
    task automatic cmp(input logic [16:0] got, input logic [16:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Button index: 0 confirm, 1 up, 2 down; one-cycle pulses
    task automatic press(input int b, input int n);
        repeat (n)
        begin
            @(posedge clk_i) #1;
            {ok, up, dn} = 3'h4 >> b;
            @(posedge clk_i) #1;
            {ok, up, dn} = 3'h0;
        end
    endtask
    task automatic go(input pct_menu_type m);
        for (int i = 0; i < 12 && menu !== m; i++)
            press(0, 1);
    endtask
    // Flips spaced five clocks; count settles four clocks after
    task automatic flip(input int n);
        repeat (n)
        begin
            @(posedge clk_i) #1 tgl = 1'b1;
            @(posedge clk_i) #1 tgl = 1'b0;
            repeat (3) @(posedge clk_i);
        end
        repeat (6) @(posedge clk_i);
    endtask
    task automatic hold(input pct_cnt_type exp);
        @(posedge clk_i) #1 hold_rst_n = 1'b0;
        repeat (4) @(posedge clk_i);
        #1 cmp(cnt, exp);
        hold_rst_n = 1'b1;
    endtask
    // Bounded wait for the display refresh, value checked when cv set
    task automatic dsp(input logic [15:0] v, input logic e, input bit cv);
        for (int i = 0; i < 200 && (disp.err !== e || (cv && disp.value !== v)); i++)
            @(posedge clk_i) #1;
        if (cv)
            cmp({1'b0, disp.value}, {1'b0, v});
        cmp({16'h0, disp.err}, {16'h0, e});
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // ==========================================================
    // Main sequence
    initial
    begin
        repeat (10) @(posedge clk_i);
        #1 sys_rst_i = 1'b0;
        repeat (3) @(posedge clk_i);
        #1 cmp(cnt, 17'sh00007);
        for (int i = 0; i < 5; i++)
        begin
            press(0, 1);
            cmp({13'h0, menu}, {13'h0, sp[i]});
            if (i == 0)
            begin
                press(1, 2);
                cmp({15'h0, cfg.src}, {15'h0, SRC_HIGH_SIDE});
                press(2, 1);
                cmp({15'h0, cfg.src}, {15'h0, SRC_LOW_SIDE});
                press(2, 1);
            end
        end
        press(1, 1);
        for (int i = 0; i < 9; i++)
        begin
            press(0, 1);
            cmp({13'h0, menu}, {13'h0, cn[i]});
            if (cn[i] == MN_DIVISOR)
                press(1, 2);
            if (cn[i] == MN_FULL_SCALE)
                press(2, 9995);
        end
        cmp({1'b0, cfg.full_scale_count}, 17'h00004);
        hold(17'sh00000);
        flip(5);
        cmp(cnt, 17'sh00001);
        go(MN_EDGE);
        press(1, 1);
        hold(17'sh00000);
        flip(5);
        cmp(cnt, 17'sh00001);
        hold(17'sh00000);
        flip(24);
        dsp(16'h270F, 1'b0, 1'b1);
        flip(6);
        cmp(cnt, 17'sh00005);
        go(MN_LIMIT);
        press(1, 1);
        dsp(16'h0000, 1'b1, 1'b0);
        press(1, 1);
        dsp(16'h270F, 1'b0, 1'b1);
        go(MN_INPUT_TYPE);
        press(1, 1);
        hold(17'sh00004);
        flip(30);
        cmp(cnt, 17'h1FFFF);
        dsp(16'h0000, 1'b0, 1'b1);
        go(MN_LIMIT);
        press(2, 1);
        dsp(16'h0000, 1'b1, 1'b0);
        // Second reset in mid-run: count comes back from storage, speed mode with one point
        @(posedge clk_i) #1 sys_rst_i = 1'b1;
        repeat (10) @(posedge clk_i);
        #1 sys_rst_i = 1'b0;
        repeat (3) @(posedge clk_i);
        #1 cmp(cnt, 17'sh00007);
        go(MN_POINT);
        press(1, 1);
        // Ten rising edges inside the first gate: 10 * 60 * 10 / 1 = 6000
        flip(20);
        repeat (1850) @(posedge clk_i);
        dsp(16'h1770, 1'b0, 1'b1);
        cmp({15'h0, disp.point}, 17'h00001);
        complete_run();
    end
endmodule // tb_pct_top
